// >>> logic/eeprom_pkg.sv
package eeprom_pkg;
    // ****************************************
    // Array geometry
    // ****************************************
    localparam int ADDR_W = 11;
    localparam int DEPTH = 2048;
    localparam int PAGE_BITS = 4;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;
    localparam logic [PAGE_BITS-1:0] PAGE_ONE = 4'h1;
    // ****************************************
    // Slave address layout
    // ****************************************
    localparam int SA_TYPE = 7;
    localparam int SA_SEL_HI = 6;
    localparam int SA_SEL_MID = 5;
    localparam int SA_SEL_LO = 4;
    localparam int SA_BLK_HI = 3;
    localparam int SA_BLK_LO = 1;
    localparam int SA_RW = 0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [7:0] BYTE_FF = 8'hff;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 25000000;
    localparam int WRITE_MS = 5;
    localparam int WRITE_CYCLES = (CLK_HZ / 1000) * WRITE_MS;
    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEVADDR = 3'b001,
        ST_WORDADDR = 3'b011,
        ST_WDATA = 3'b010,
        ST_RDATA = 3'b110,
        ST_ACKOUT = 3'b111,
        ST_ACKIN = 3'b101
    } state_e;
    // Synchronised bus view
    typedef struct packed {
        logic scl;
        logic sda;
    } bus_s;
endpackage

// >>> logic/two_wire_eeprom_slave.sv
`timescale 1ns/1ns
// Operation
// - Data changes only while clock low
// - Start is data fall, clock high
// - Ignore bus until start seen
// - Stop is data rise, clock high
// - Ninth clock carries receiver acknowledge
// - Data pin only pulled low
// - Acknowledge matching address and written bytes
// - Read sends byte, samples master acknowledge
// - No acknowledge ends read transmission
// - Top bit one, three select bits
// - Middle select bit compares inverted
// - Three block bits extend word address
// - Last bit one reads, zero writes
// - Stop after write starts internal write
// - Busy device ignores every request
// - Internal write lasts write-cycle time
// - Page holds up to sixteen bytes
// - Page increments only low four bits
// - Page overflow wraps, overwrites
// - Device is slave only
// - No acknowledge while busy
// - Address counter holds last plus one
module two_wire_eeprom_slave import eeprom_pkg::*; #(
    parameter int INTERNAL_WRITE_CYCLES = WRITE_CYCLES
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Two-wire bus
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // Device select pins
    input wire logic SELECT_PIN_LOW_I,
    input wire logic SELECT_PIN_MID_INVERTED_I,
    input wire logic SELECT_PIN_HIGH_I,
    // Status
    output logic WRITE_BUSY_O
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic [2:0] sel_lo_sync;
    logic [2:0] sel_mid_sync;
    logic [2:0] sel_hi_sync;
    bus_s bus;
    bus_s bus_prev;
    logic sel_lo;
    logic sel_mid;
    logic sel_hi;

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            sel_lo_sync <= 3'h0;
            sel_mid_sync <= 3'h0;
            sel_hi_sync <= 3'h0;
        end else begin
            scl_sync <= {scl_sync[1:0], SCL_I};
            sda_sync <= {sda_sync[1:0], SDA_I};
            sel_lo_sync <= {sel_lo_sync[1:0], SELECT_PIN_LOW_I};
            sel_mid_sync <= {sel_mid_sync[1:0], SELECT_PIN_MID_INVERTED_I};
            sel_hi_sync <= {sel_hi_sync[1:0], SELECT_PIN_HIGH_I};
        end
    end

    // Filtered levels change only when stages two and three agree
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bus <= '{scl: 1'b1, sda: 1'b1};
            bus_prev <= '{scl: 1'b1, sda: 1'b1};
            sel_lo <= 1'b0;
            sel_mid <= 1'b0;
            sel_hi <= 1'b0;
        end else begin
            bus_prev <= bus;
            if (scl_sync[1] == scl_sync[2]) begin
                bus.scl <= scl_sync[2];
            end
            if (sda_sync[1] == sda_sync[2]) begin
                bus.sda <= sda_sync[2];
            end
            if (sel_lo_sync[1] == sel_lo_sync[2]) begin
                sel_lo <= sel_lo_sync[2];
            end
            if (sel_mid_sync[1] == sel_mid_sync[2]) begin
                sel_mid <= sel_mid_sync[2];
            end
            if (sel_hi_sync[1] == sel_hi_sync[2]) begin
                sel_hi <= sel_hi_sync[2];
            end
        end
    end

    // ****************************************
    // Bus event decode
    // ****************************************
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    // data edge with clock high is framing
    assign start_det = bus.scl && bus_prev.scl && bus_prev.sda && !bus.sda;
    assign stop_det = bus.scl && bus_prev.scl && !bus_prev.sda && bus.sda;
    assign scl_rise = bus.scl && !bus_prev.scl;
    assign scl_fall = !bus.scl && bus_prev.scl;

    // ****************************************
    // Sequencer
    // ****************************************
    state_e state;
    state_e after_ack;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] tx_byte;
    logic [ADDR_W-1:0] addr_cnt;
    logic [2:0] blk_bits;
    logic is_write;
    logic sda_low;
    logic master_ack;
    logic [31:0] busy_cnt;
    logic busy;
    logic pending_write;
    logic [7:0] mem [DEPTH];
    logic [7:0] page_buf [1 << PAGE_BITS];
    logic [(1 << PAGE_BITS)-1:0] page_valid;
    logic [ADDR_W-1:0] page_base;
    logic [7:0] rx_byte;
    logic addr_match;

    assign rx_byte = {shreg[6:0], bus.sda};
    // fixed top bit and select bits
    assign addr_match = rx_byte[SA_TYPE] && (rx_byte[SA_SEL_HI] == sel_hi)
        && (rx_byte[SA_SEL_MID] == !sel_mid) && (rx_byte[SA_SEL_LO] == sel_lo);

    // Main two-wire sequencer, sampling on clock rise and driving on fall
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state <= ST_IDLE;
            after_ack <= ST_IDLE;
            bit_cnt <= BIT_ZERO;
            shreg <= 8'h00;
            tx_byte <= 8'h00;
            addr_cnt <= '0;
            blk_bits <= 3'h0;
            is_write <= 1'b0;
            sda_low <= 1'b0;
            master_ack <= 1'b0;
            pending_write <= 1'b0;
            page_valid <= '0;
            page_base <= '0;
        end else if (busy) begin
            state <= ST_IDLE;
            sda_low <= 1'b0;
            pending_write <= 1'b0;
            page_valid <= '0;
        end else if (stop_det) begin
            state <= ST_IDLE;
            sda_low <= 1'b0;
            pending_write <= |page_valid;
        end else if (start_det) begin
            // only a start wakes the sequencer
            state <= ST_DEVADDR;
            bit_cnt <= BIT_ZERO;
            sda_low <= 1'b0;
            page_valid <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    sda_low <= 1'b0;
                end
                ST_DEVADDR, ST_WORDADDR, ST_WDATA: begin
                    if (scl_rise) begin
                        shreg <= rx_byte;
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == BIT_LAST) begin
                            bit_cnt <= BIT_ZERO;
                            after_ack <= ST_IDLE;
                            if (state == ST_DEVADDR) begin
                                if (addr_match) begin
                                    is_write <= !rx_byte[SA_RW];
                                    blk_bits <= rx_byte[SA_BLK_HI:SA_BLK_LO];
                                    after_ack <= rx_byte[SA_RW] ? ST_RDATA : ST_WORDADDR;
                                    state <= ST_ACKOUT;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end else if (state == ST_WORDADDR) begin
                                addr_cnt <= {blk_bits, rx_byte};
                                page_base <= {blk_bits, rx_byte};
                                after_ack <= ST_WDATA;
                                state <= ST_ACKOUT;
                            end else begin
                                page_buf[addr_cnt[PAGE_BITS-1:0]] <= rx_byte;
                                page_valid[addr_cnt[PAGE_BITS-1:0]] <= 1'b1;
                                addr_cnt[PAGE_BITS-1:0] <= addr_cnt[PAGE_BITS-1:0] + PAGE_ONE;
                                after_ack <= ST_WDATA;
                                state <= ST_ACKOUT;
                            end
                        end
                    end
                end
                ST_ACKOUT: begin
                    // pull low through the ninth clock
                    if (scl_fall && !sda_low) begin
                        sda_low <= 1'b1;
                    end else if (scl_fall && sda_low) begin
                        sda_low <= 1'b0;
                        state <= after_ack;
                        if (after_ack == ST_RDATA) begin
                            tx_byte <= mem[addr_cnt];
                            sda_low <= !mem[addr_cnt][BIT_LAST[2:0]];
                            addr_cnt <= addr_cnt + ADDR_ONE;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == BIT_LAST) begin
                            bit_cnt <= BIT_ZERO;
                            sda_low <= 1'b0;
                            state <= ST_ACKIN;
                        end else begin
                            sda_low <= !tx_byte[3'h6 - bit_cnt[2:0]];
                        end
                    end
                end
                ST_ACKIN: begin
                    if (scl_rise) begin
                        master_ack <= !bus.sda;
                    end else if (scl_fall) begin
                        if (master_ack) begin
                            tx_byte <= mem[addr_cnt];
                            sda_low <= !mem[addr_cnt][BIT_LAST[2:0]];
                            addr_cnt <= addr_cnt + ADDR_ONE;
                            state <= ST_RDATA;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    sda_low <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Internal write cycle
    // ****************************************
    // self-timed busy window
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            busy_cnt <= 32'h0;
            busy <= 1'b0;
        end else if (pending_write && !busy) begin
            busy_cnt <= 32'(INTERNAL_WRITE_CYCLES - 1);
            busy <= 1'b1;
        end else if (busy) begin
            if (busy_cnt == 32'h0) begin
                busy <= 1'b0;
            end else begin
                busy_cnt <= busy_cnt - 32'h1;
            end
        end
    end

    // Array commit happens once, at the start of the busy window
    always_ff @(posedge CLK_I) begin
        if (pending_write && !busy) begin
            for (int i = 0; i < (1 << PAGE_BITS); i++) begin
                if (page_valid[i]) begin
                    mem[{page_base[ADDR_W-1:PAGE_BITS], PAGE_BITS'(i)}] <= page_buf[i];
                end
            end
        end
    end

    // slave only, never drives the clock
    assign SDA_O = 1'b0;
    assign SDA_OE_O = sda_low;
    assign WRITE_BUSY_O = busy;
endmodule

// >>> tb/two_wire_master.sv
`timescale 1ns/1ns
// ****
// Bus master model
// ****
module two_wire_master (
    // Clock and bus
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // Idle bus: clock stands high, data released to the pull-up
    // master owns clock
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Start is (1,0), stop is (0,1); clock is left at level b
    // start and stop
    task automatic cond(input logic a, input logic b);
        wt(1);
        sda_o = a;
        wt(4);
        scl_o = 1'b1;
        wt(3);
        sda_o = b;
        wt(4);
        scl_o = b;
    endtask
    // Long low phase leaves room for the slave's sync delay
    // data moves with clock low
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            wt(1);
            sda_o = tx[i];
            wt(4);
            scl_o = 1'b1;
            wt(2);
            rx[i] = sda_i;
            wt(1);
            scl_o = 1'b0;
        end
    endtask
endmodule

// >>> tb/eeprom_bus_monitor.sv
`timescale 1ns/1ns
module eeprom_bus_monitor #(
    parameter int INTERNAL_WRITE_CYCLES = 125000
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Bus and status
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    input wire logic WRITE_BUSY_O
);
    logic scl_q, sda_q, started, oe_seen;
    logic [3:0] falls, gap;
    int bcnt;
    // Raw conditions, seen before the design's synchronised view
    wire logic st = scl_q & SCL_I & sda_q & ~SDA_I;
    wire logic sp = scl_q & SCL_I & ~sda_q & SDA_I;
    // Falls and gap saturate, bcnt clears while not busy, so a long idle cannot wrap them
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            {scl_q, sda_q, started, oe_seen} <= 4'hc;
            falls <= 4'h0;
            gap <= 4'hf;
            bcnt <= 0;
        end else begin
            {scl_q, sda_q} <= {SCL_I, SDA_I};
            started <= started | st;
            oe_seen <= ~st & (oe_seen | SDA_OE_O);
            falls <= st ? 4'h0 : falls + {3'h0, scl_q & ~SCL_I & (falls != 4'hf)};
            gap <= sp ? 4'h0 : gap + {3'h0, gap != 4'hf};
            bcnt <= WRITE_BUSY_O ? bcnt + 1 : 0;
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence hold_s;
        SDA_OE_O [*6];
    endsequence
    pin_low_a: assert property (SDA_O == 1'b0)
        else $error("data pin driven high");
    idle_quiet_a: assert property (!started |-> !SDA_OE_O)
        else $error("drive before any start");
    addr_ack_a: assert property ($rose(SDA_OE_O) && !oe_seen |-> falls == 4'h9)
        else $error("address ack on wrong clock");
    // change with clock low; the edge that moved the pin is five samples back, the clock still low one sample back
    scl_low_a: assert property ($changed(SDA_OE_O) |-> !$past(SCL_I))
        else $error("data moved with clock high");
    ack_hold_a: assert property ($rose(SDA_OE_O) |-> hold_s)
        else $error("drive too short");
    busy_quiet_a: assert property (WRITE_BUSY_O |-> !SDA_OE_O)
        else $error("answer while busy");
    busy_cause_a: assert property ($rose(WRITE_BUSY_O) |-> gap < 4'hc)
        else $error("write cycle without stop");
    busy_len_a: assert property ($fell(WRITE_BUSY_O) |->
        bcnt >= INTERNAL_WRITE_CYCLES - 1 && bcnt <= INTERNAL_WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
endmodule
bind two_wire_eeprom_slave eeprom_bus_monitor #(.INTERNAL_WRITE_CYCLES(INTERNAL_WRITE_CYCLES)) u_monitor (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
    .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .WRITE_BUSY_O(WRITE_BUSY_O));

// >>> tb/tb_top.sv
`timescale 1ns/1ns
module tb_top import eeprom_pkg::*; ();
    localparam int WCYC = 400;
    logic clk, rst_n, sel_lo, sel_mid, sel_hi, busy, sda_oe, scl, sda_m;
    logic [7:0] mem [DEPTH];
    int n_fail = 0;
    int n_tests = 0;
    // Pull-up: the bus reads high unless someone pulls it low
    wire logic sda = sda_m & ~sda_oe;
    two_wire_eeprom_slave #(.INTERNAL_WRITE_CYCLES(WCYC)) i_two_wire_eeprom_slave (
        .CLK_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe),
        .SELECT_PIN_LOW_I(sel_lo), .SELECT_PIN_MID_INVERTED_I(sel_mid),
        .SELECT_PIN_HIGH_I(sel_hi), .WRITE_BUSY_O(busy));
    two_wire_master i_m (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Middle select bit goes inverted on the wire
    function automatic logic [7:0] dev(input logic [2:0] blk, input logic rw);
        return {1'b1, sel_hi, ~sel_mid, sel_lo, blk, rw};
    endfunction
    task automatic put(input logic [7:0] b, input logic ack);
        logic [8:0] rx;
        i_m.xfer({b, 1'b1}, rx);
        check({7'h0, rx[0]}, {7'h0, ~ack});
    endtask
    task automatic get(output logic [7:0] d, input logic nack);
        logic [8:0] rx;
        i_m.xfer({8'hff, nack}, rx);
        d = rx[8:1];
    endtask
    task automatic seek(input logic [ADDR_W-1:0] a);
        i_m.cond(1'b1, 1'b0);
        put(dev(a[10:8], 1'b0), 1'b1);
        put(a[7:0], 1'b1);
    endtask
    // Poll until the write cycle ends; the first poll must go unanswered
    task automatic idle();
        logic [8:0] rx;
        int polls = 0;
        repeat (8) @(negedge clk);
        check({7'h0, busy}, 8'h1);
        do begin
            i_m.cond(1'b1, 1'b0);
            i_m.xfer({dev(3'h0, 1'b0), 1'b1}, rx);
            i_m.cond(1'b0, 1'b1);
            polls++;
        end while (rx[0] !== 1'b0 && polls < 40);
        // Polling must end on an answer, not on the poll limit
        check({7'h0, rx[0]}, 8'h0);
        check({7'h0, polls > 1}, 8'h1);
        check({7'h0, busy}, 8'h0);
    endtask
    task automatic complete_run();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end
    initial begin
        logic [7:0] d;
        logic [ADDR_W-1:0] a;
        void'($urandom(87702));
        {rst_n, sel_hi, sel_mid, sel_lo} = 4'h0;
        repeat (16) @(negedge clk);
        check({6'h0, sda_oe, busy}, 8'h0);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        // Each select setting: one flipped top or select bit is refused
        for (int k = 0; k < 8; k++) begin
            {sel_hi, sel_mid, sel_lo} = 3'(k);
            i_m.cond(1'b1, 1'b0);
            put(dev(3'(k), 1'b0) ^ (8'h10 << k[1:0]), 1'b0);
            i_m.cond(1'b1, 1'b0);
            put(dev(3'(k), 1'b0), 1'b1);
            i_m.cond(1'b0, 1'b1);
        end
        a = ADDR_W'($urandom);
        d = 8'($urandom);
        mem[a] = d;
        seek(a);
        put(d, 1'b1);
        i_m.cond(1'b0, 1'b1);
        idle();
        seek(a);
        i_m.cond(1'b1, 1'b0);
        put(dev(a[10:8], 1'b1), 1'b1);
        get(d, 1'b1);
        check(d, mem[a]);
        i_m.cond(1'b0, 1'b1);
        // Eighteen bytes from a random offset: the last two wrap onto the first
        a = ADDR_W'($urandom);
        seek(a);
        for (int j = 0; j < 18; j++) begin
            d = 8'($urandom);
            mem[{a[10:4], a[3:0] + 4'(j)}] = d;
            put(d, 1'b1);
        end
        i_m.cond(1'b0, 1'b1);
        idle();
        seek({a[10:4], 4'h0});
        i_m.cond(1'b1, 1'b0);
        put(dev(a[10:8], 1'b1), 1'b1);
        for (int j = 0; j < 15; j++) begin
            get(d, j == 14);
            check(d, mem[{a[10:4], 4'(j)}]);
        end
        // A refused byte must not be followed by another one while the clock idles low
        repeat (6) @(negedge clk);
        check({7'h0, sda_oe}, 8'h0);
        i_m.cond(1'b0, 1'b1);
        check({7'h0, sda}, 8'h1);
        // Current address read resumes after the last byte read
        i_m.cond(1'b1, 1'b0);
        put(dev(a[10:8], 1'b1), 1'b1);
        get(d, 1'b1);
        check(d, mem[{a[10:4], 4'hf}]);
        i_m.cond(1'b0, 1'b1);
        complete_run();
    end
endmodule
